// ===== rtl/hpps_defs.vh
`ifndef HPPS_DEFS_VH
`define HPPS_DEFS_VH
// register indexes on the command port (read index; write sets bit 7)
`define HPPS_IDX_RUN_CONTROL 7'h01
`define HPPS_IDX_EVENT_STATUS 7'h03
`define HPPS_IDX_PORT_CONFIG 7'h20
`define HPPS_IDX_CPU_FLAGS 7'h24
`define HPPS_CMD_WRITE_BIT 7
// run control functional-state field
`define HPPS_FS_LSB 6
`define HPPS_FS_MSB 7
`define HPPS_FS_RESET 2'h0
`define HPPS_FS_RESUME 2'h1
`define HPPS_FS_OPER 2'h2
`define HPPS_FS_SUSPEND 2'h3
// event status fields
`define HPPS_RESUME_SEEN_BIT 3
// port and power config fields
`define HPPS_INT_OC_BIT 10
`define HPPS_KEEP_CLK_BIT 11
`define HPPS_INT_PD_BIT 12
`define HPPS_CONFIG_RESET 16'h0000
// processor event flags fields
`define HPPS_CLK_UP_BIT 6
// timing, in ns, and derived cycle counts at 10 ns
`define HPPS_CLK_PERIOD_NS 10
`define HPPS_STOP_DELAY_NS 1300000
`define HPPS_WAKE_UP_NS 160000
`define HPPS_AWAKE_HOLD_NS 1140000
`define HPPS_STOP_DELAY_CYC (`HPPS_STOP_DELAY_NS / `HPPS_CLK_PERIOD_NS)
`define HPPS_WAKE_UP_CYC (`HPPS_WAKE_UP_NS / `HPPS_CLK_PERIOD_NS)
// a wake edge reaches the sequencer this many cycles late (sync and edge detect)
`define HPPS_WAKE_SYNC_CYC 5
`define HPPS_AWAKE_HOLD_CYC ((`HPPS_AWAKE_HOLD_NS + `HPPS_CLK_PERIOD_NS - 1) / `HPPS_CLK_PERIOD_NS)
`endif

// ===== rtl/hpps_port_power.v
`include "hpps_defs.vh"
module hpps_port_power (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire overcurrent_n_i,
  input wire analog_overcurrent_i,
  input wire internal_overcurrent_select_i,
  output reg power_switch_n_o,
  output wire power_switch_n_oe_o
);
  wire oc_ext_n;
  wire oc_ana;
  wire oc_now;
  hpps_sync u_ext (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(~overcurrent_n_i),
    .level_o(oc_ext_n)
  );
  hpps_sync u_ana (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(analog_overcurrent_i),
    .level_o(oc_ana)
  );
  assign oc_now = internal_overcurrent_select_i ? oc_ana : oc_ext_n;
  // open drain: high means released, so drive only while low
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      power_switch_n_o <= 1'b1;
    end else begin
      power_switch_n_o <= oc_now;
    end
  end
  assign power_switch_n_oe_o = ~power_switch_n_o;
endmodule // hpps_port_power

// ===== rtl/hpps_sync.v
module hpps_sync (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire async_i,
  output reg level_o
);
  reg s1_q;
  reg s2_q;
  reg s3_q;
  // change accepted once second and third stages agree
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      level_o <= 1'b0;
    end else begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_o <= s3_q;
      end
    end
  end
endmodule // hpps_sync

// ===== rtl/hpps_top.v
// Overview of operation
// - config bit 12 connects the four internal port pull-downs
// - every reset clears the internal pull-down select bit
// - config bit 10 picks internal overcurrent sensing, resets to external
// - two ports, each with open-drain switch output and overcurrent input
// - overcurrent turns port power off, otherwise power stays on
// - writing suspend into the functional-state field suspends the host
// - suspend output rises on suspend, falls only on reset or operational
// - clock stops 1.3 ms into suspend unless config bit 11 set
// - full chip suspend only when host and device both suspended
// - wake pulse restarts clock and sets clock-up flag bit 6
// - clock is running 160 us after wake rises during suspend
// - after wake clock runs 1.14 ms, longer while wake high or operational
// - chip select during suspend acts as software wakeup
// - port resume moves suspend to resume and sets flag bit 3
`include "hpps_defs.vh"
module hpps_top (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire soft_reset_i,
  input wire chip_select_n_i,
  input wire cmd_strobe_i,
  input wire data_wr_strobe_i,
  input wire data_rd_strobe_i,
  input wire [15:0] data_i,
  output reg [15:0] data_o,
  input wire port1_overcurrent_n_i,
  input wire port2_overcurrent_n_i,
  input wire [1:0] analog_overcurrent_i,
  output wire port1_power_switch_n_o,
  output wire port1_power_switch_n_oe_o,
  output wire port2_power_switch_n_o,
  output wire port2_power_switch_n_oe_o,
  output wire [3:0] pulldown_enable_o,
  input wire host_wakeup_i,
  input wire port_resume_i,
  input wire device_controller_suspended_i,
  output reg host_suspend_o,
  output reg clock_enable_o,
  output wire full_suspend_o
);
  ////////////////////////////////////////////////////////////////////////////
  reg [6:0] index_q;
  reg write_pending_q;
  reg [15:0] low_word_q;
  reg word_half_q;
  reg [1:0] func_state_q;
  reg [31:0] run_control_q;
  reg resume_seen_flag_q;
  reg [15:0] config_q;
  reg clock_up_flag_q;
  reg [20:0] stop_cnt_q;
  reg [20:0] wake_cnt_q;
  reg [20:0] hold_cnt_q;
  reg [1:0] wake_state_q;
  reg wake_prev_q;
  reg cs_prev_q;
  wire wake_lvl;
  wire cs_lvl;
  wire resume_lvl;
  wire any_reset;
  wire wake_rise;
  wire cs_fall;
  wire [31:0] wr_word;
  wire wr_done;
  wire internal_overcurrent_select;
  wire keep_clock_in_sleep;
  wire internal_pulldown_select;
  wire in_suspend;
  wire any_wake;
  wire [31:0] wake_load_full;
  wire [31:0] hold_load_full;
  wire [1:0] ext_oc_n;
  wire [1:0] sw_n;
  wire [1:0] sw_oe;
  reg [15:0] run_lo_word;
  reg [15:0] evt_lo_word;
  reg [15:0] flags_word;
  localparam WS_RUN = 2'h0;
  localparam WS_SLEEP = 2'h1;
  localparam WS_STARTUP = 2'h2;
  localparam WS_AWAKE = 2'h3;
  assign any_reset = ~rst_n_i | soft_reset_i;
  assign internal_overcurrent_select = config_q[`HPPS_INT_OC_BIT];
  assign keep_clock_in_sleep = config_q[`HPPS_KEEP_CLK_BIT];
  assign internal_pulldown_select = config_q[`HPPS_INT_PD_BIT];
  assign pulldown_enable_o = {4{internal_pulldown_select}};
  // the stop count runs only in the suspend state, not in resume
  assign in_suspend = (func_state_q == `HPPS_FS_SUSPEND);
  // counter loads, cut to the counter width; the wake load leaves room for the
  // synchroniser and edge detector so the clock is up in time
  assign wake_load_full = `HPPS_WAKE_UP_CYC - `HPPS_WAKE_SYNC_CYC - 1;
  assign hold_load_full = `HPPS_AWAKE_HOLD_CYC - 1;
  ////////////////////////////////////////////////////////////////////////////
  hpps_sync u_wake (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(host_wakeup_i),
    .level_o(wake_lvl)
  );
  hpps_sync u_cs (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(~chip_select_n_i),
    .level_o(cs_lvl)
  );
  hpps_sync u_resume (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .async_i(port_resume_i),
    .level_o(resume_lvl)
  );
  assign wake_rise = wake_lvl & ~wake_prev_q;
  assign cs_fall = cs_lvl & ~cs_prev_q;
  assign any_wake = wake_rise | cs_fall | resume_lvl;
  ////////////////////////////////////////////////////////////////////////////
  // port power, each port handled on its own
  assign ext_oc_n = {port2_overcurrent_n_i, port1_overcurrent_n_i};
  assign port1_power_switch_n_o = sw_n[0];
  assign port1_power_switch_n_oe_o = sw_oe[0];
  assign port2_power_switch_n_o = sw_n[1];
  assign port2_power_switch_n_oe_o = sw_oe[1];
  genvar port_idx;
  generate
    for (port_idx = 0; port_idx < 2; port_idx = port_idx + 1) begin : g_port
      hpps_port_power u_port (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(~any_reset),
        .overcurrent_n_i(ext_oc_n[port_idx]),
        .analog_overcurrent_i(analog_overcurrent_i[port_idx]),
        .internal_overcurrent_select_i(internal_overcurrent_select),
        .power_switch_n_o(sw_n[port_idx]),
        .power_switch_n_oe_o(sw_oe[port_idx])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // command/data port: command word carries index and write bit;
  // 32-bit registers take two data words, low first
  assign wr_word = {data_i, low_word_q};
  assign wr_done = data_wr_strobe_i & ~chip_select_n_i & write_pending_q;
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      index_q <= 7'h00;
      write_pending_q <= 1'b0;
      word_half_q <= 1'b0;
      low_word_q <= 16'h0000;
    end else if (!chip_select_n_i) begin
      if (cmd_strobe_i) begin
        index_q <= data_i[6:0];
        write_pending_q <= data_i[`HPPS_CMD_WRITE_BIT];
        word_half_q <= 1'b0;
      end else if (data_wr_strobe_i || data_rd_strobe_i) begin
        if ((index_q == `HPPS_IDX_RUN_CONTROL) || (index_q == `HPPS_IDX_EVENT_STATUS)) begin
          word_half_q <= ~word_half_q;
          if (!word_half_q) begin
            low_word_q <= data_i;
          end
        end
      end
    end
  end
  wire wr_run = wr_done && (index_q == `HPPS_IDX_RUN_CONTROL) && word_half_q;
  wire wr_evt = wr_done && (index_q == `HPPS_IDX_EVENT_STATUS) && word_half_q;
  wire wr_cfg = wr_done && (index_q == `HPPS_IDX_PORT_CONFIG);
  wire wr_flg = wr_done && (index_q == `HPPS_IDX_CPU_FLAGS);
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      config_q <= `HPPS_CONFIG_RESET;
    end else if (wr_cfg) begin
      config_q <= data_i;
    end
  end
  // run control: functional state also moved by resume signalling
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      run_control_q <= 32'h0000_0000;
      func_state_q <= `HPPS_FS_RESET;
    end else if (wr_run) begin
      run_control_q <= wr_word;
      func_state_q <= wr_word[`HPPS_FS_MSB:`HPPS_FS_LSB];
    end else if (func_state_q == `HPPS_FS_SUSPEND && resume_lvl) begin
      func_state_q <= `HPPS_FS_RESUME;
    end
  end
  // flags: set wins over write-one-to-clear
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      resume_seen_flag_q <= 1'b0;
      clock_up_flag_q <= 1'b0;
    end else begin
      if (func_state_q == `HPPS_FS_SUSPEND && resume_lvl) begin
        resume_seen_flag_q <= 1'b1;
      end else if (wr_evt && wr_word[`HPPS_RESUME_SEEN_BIT]) begin
        resume_seen_flag_q <= 1'b0;
      end
      if (wake_state_q == WS_STARTUP && wake_cnt_q == 21'd0) begin
        clock_up_flag_q <= 1'b1;
      end else if (wr_flg && data_i[`HPPS_CLK_UP_BIT]) begin
        clock_up_flag_q <= 1'b0;
      end
    end
  end
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      host_suspend_o <= 1'b0;
    end else if (func_state_q == `HPPS_FS_SUSPEND) begin
      host_suspend_o <= 1'b1;
    end else if (func_state_q == `HPPS_FS_RESET || func_state_q == `HPPS_FS_OPER) begin
      host_suspend_o <= 1'b0;
    end
  end
  assign full_suspend_o = host_suspend_o & device_controller_suspended_i & ~clock_enable_o;
  ////////////////////////////////////////////////////////////////////////////
  // clock-stop sequencer; clock_enable_o gates the internal clock tree
  // wake sources start the clock only from WS_SLEEP; in WS_STARTUP it is already starting, elsewhere it runs
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      wake_state_q <= WS_RUN;
      clock_enable_o <= 1'b1;
      stop_cnt_q <= 21'd0;
      wake_cnt_q <= 21'd0;
      hold_cnt_q <= 21'd0;
      wake_prev_q <= 1'b0;
      cs_prev_q <= 1'b0;
    end else begin
      wake_prev_q <= wake_lvl;
      cs_prev_q <= cs_lvl;
      case (wake_state_q)
        WS_RUN: begin
          clock_enable_o <= 1'b1;
          if (in_suspend && !keep_clock_in_sleep) begin
            if (stop_cnt_q == `HPPS_STOP_DELAY_CYC - 1) begin
              wake_state_q <= WS_SLEEP;
              clock_enable_o <= 1'b0;
              stop_cnt_q <= 21'd0;
            end else begin
              stop_cnt_q <= stop_cnt_q + 21'd1;
            end
          end else begin
            stop_cnt_q <= 21'd0;
          end
        end
        WS_SLEEP: begin
          if (any_wake) begin
            wake_state_q <= WS_STARTUP;
            wake_cnt_q <= wake_load_full[20:0];
          end
        end
        WS_STARTUP: begin
          if (wake_cnt_q == 21'd0) begin
            clock_enable_o <= 1'b1;
            wake_state_q <= WS_AWAKE;
            hold_cnt_q <= hold_load_full[20:0];
          end else begin
            wake_cnt_q <= wake_cnt_q - 21'd1;
          end
        end
        WS_AWAKE: begin
          if (func_state_q != `HPPS_FS_SUSPEND) begin
            wake_state_q <= WS_RUN;
          end else if (wake_lvl || hold_cnt_q != 21'd0) begin
            if (hold_cnt_q != 21'd0) begin
              hold_cnt_q <= hold_cnt_q - 21'd1;
            end
          end else begin
            wake_state_q <= WS_SLEEP;
            clock_enable_o <= 1'b0;
          end
        end
        default: wake_state_q <= WS_RUN;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // readback words built from the field positions
  always @* begin
    run_lo_word = run_control_q[15:0];
    run_lo_word[`HPPS_FS_MSB:`HPPS_FS_LSB] = func_state_q;
  end
  always @* begin
    evt_lo_word = 16'h0000;
    evt_lo_word[`HPPS_RESUME_SEEN_BIT] = resume_seen_flag_q;
  end
  always @* begin
    flags_word = 16'h0000;
    flags_word[`HPPS_CLK_UP_BIT] = clock_up_flag_q;
  end
  always @(posedge sys_clk_i) begin
    if (any_reset) begin
      data_o <= 16'h0000;
    end else begin
      case (index_q)
        `HPPS_IDX_RUN_CONTROL: data_o <= word_half_q ? run_control_q[31:16] : run_lo_word;
        `HPPS_IDX_EVENT_STATUS: data_o <= word_half_q ? 16'h0000 : evt_lo_word;
        `HPPS_IDX_PORT_CONFIG: data_o <= config_q;
        `HPPS_IDX_CPU_FLAGS: data_o <= flags_word;
        default: data_o <= 16'h0000;
      endcase
    end
  end
endmodule // hpps_top

// ===== tb/hpps_checker.sv
module hpps_checker (
  input wire sys_clk_i,
  input wire rst_n_i,
  input wire soft_reset_i,
  input wire data_wr_strobe_i,
  input wire port1_overcurrent_n_i,
  input wire port2_overcurrent_n_i,
  input wire [1:0] analog_overcurrent_i,
  input wire port1_power_switch_n_o,
  input wire port1_power_switch_n_oe_o,
  input wire port2_power_switch_n_o,
  input wire [3:0] pulldown_enable_o,
  input wire device_controller_suspended_i,
  input wire host_suspend_o,
  input wire full_suspend_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] wr_age_q;
  // cycles since the last data word write, saturating
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i || data_wr_strobe_i) wr_age_q <= 4'h0;
    else if (wr_age_q != 4'hf) wr_age_q <= wr_age_q + 4'h1;
  end
  default clocking @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  pd_clear_a: assert property (soft_reset_i |=> pulldown_enable_o == 4'h0)
    else $error("pull-downs kept over reset");
  pd_group_a: assert property (pulldown_enable_o == 4'h0 || pulldown_enable_o == 4'hf)
    else $error("pull-downs split");
  oc1_off_a: assert property ((!port1_overcurrent_n_i && analog_overcurrent_i[0])[*8]
      |-> port1_power_switch_n_o) else $error("port 1 powered in overcurrent");
  oc2_on_a: assert property ((port2_overcurrent_n_i && !analog_overcurrent_i[1]
      && !soft_reset_i)[*8] |-> !port2_power_switch_n_o) else $error("port 2 unpowered");
  oe_pair_a: assert property (port1_power_switch_n_oe_o == !port1_power_switch_n_o)
    else $error("port 1 enable wrong");
  full_a: assert property (full_suspend_o |-> host_suspend_o && device_controller_suspended_i)
    else $error("full suspend too early");
  susp_rise_a: assert property ($rose(host_suspend_o) |-> wr_age_q < 4'h8)
    else $error("suspend without write");
  susp_fall_a: assert property ($fell(host_suspend_o) |-> wr_age_q < 4'h8
      || $past(soft_reset_i) || !$past(rst_n_i)) else $error("suspend dropped alone");
endmodule // hpps_checker

// ===== tb/hpps_port_model.sv
module hpps_port_model (
  input wire logic [1:0] sw_n_i,
  input wire logic [1:0] sw_oe_i,
  input wire logic [1:0] ext_fault_i,
  input wire logic [1:0] int_fault_i,
  output logic [1:0] oc_n_o,
  output logic [1:0] analog_oc_o,
  output logic [1:0] powered_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // a released gate is pulled up, which turns the switch off
  assign powered_o = sw_oe_i & ~sw_n_i;
  // each sensor reports its own port only
  assign oc_n_o = ~ext_fault_i;
  assign analog_oc_o = int_fault_i;
endmodule // hpps_port_model

// ===== tb/hpps_top_tb.sv
`include "hpps_defs.vh"
module hpps_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 0, rst_n_i = 0, soft_reset_i = 0, chip_select_n_i = 1;
  logic cmd_strobe_i = 0, data_wr_strobe_i = 0, data_rd_strobe_i = 0;
  logic host_wakeup_i = 0, port_resume_i = 0, device_controller_suspended_i = 0;
  logic [15:0] data_i = 16'h0000; // register words only, never frame data
  logic [1:0] ext_f = 2'h0, int_f = 2'h0;
  wire [1:0] oc_n, aoc, pwr, sw, oe;
  wire [15:0] data_o;
  wire [3:0] pulldown_enable_o;
  wire host_suspend_o, clock_enable_o, full_suspend_o;
  int errors = 0, n_tests = 0, cyc = 0;
  hpps_top u_dut (.sys_clk_i, .rst_n_i, .soft_reset_i, .chip_select_n_i, .cmd_strobe_i,
    .data_wr_strobe_i, .data_rd_strobe_i, .data_i, .data_o, .port1_overcurrent_n_i(oc_n[0]),
    .port2_overcurrent_n_i(oc_n[1]), .analog_overcurrent_i(aoc), .port1_power_switch_n_o(sw[0]),
    .port1_power_switch_n_oe_o(oe[0]), .port2_power_switch_n_o(sw[1]),
    .port2_power_switch_n_oe_o(oe[1]), .pulldown_enable_o, .host_wakeup_i, .port_resume_i,
    .device_controller_suspended_i, .host_suspend_o, .clock_enable_o, .full_suspend_o);
  hpps_port_model u_ports (.sw_n_i(sw), .sw_oe_i(oe), .ext_fault_i(ext_f),
    .int_fault_i(int_f), .oc_n_o(oc_n), .analog_oc_o(aoc), .powered_o(pwr));
  always #5 sys_clk_i = ~sys_clk_i;
  always @(posedge sys_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  // k: 0 soft reset, 1 command, 2 data write, 3 data read
  task automatic pulse(input int k, input logic [15:0] v);
    @(posedge sys_clk_i);
    #1 data_i = v;
    chip_select_n_i = 0;
    {soft_reset_i, cmd_strobe_i, data_wr_strobe_i, data_rd_strobe_i} = 4'h8 >> k;
    @(posedge sys_clk_i);
    #1 {soft_reset_i, cmd_strobe_i, data_wr_strobe_i, data_rd_strobe_i} = 4'h0;
  endtask
  // a whole update takes a few cycles, far inside a frame gap
  task automatic wr(input logic [6:0] idx, input logic [31:0] v, input bit two);
    pulse(1, {8'h00, 1'b1, idx});
    pulse(2, v[15:0]);
    if (two) pulse(2, v[31:16]);
    chip_select_n_i = 1;
  endtask
  task automatic rd(input logic [6:0] idx, input logic [15:0] mask, input logic [15:0] exp);
    pulse(1, {9'h000, idx});
    idle(1);
    check(data_o & mask, exp);
    pulse(3, 16'h0000);
    chip_select_n_i = 1;
  endtask
  task automatic t_pulldown();
    idle(10);
    check(pulldown_enable_o, 4'h0);
    rd(`HPPS_IDX_PORT_CONFIG, 16'hffff, 16'h0000);
    wr(`HPPS_IDX_PORT_CONFIG, 32'h1000, 0);
    idle(3);
    check(pulldown_enable_o, 4'hf);
    rd(`HPPS_IDX_PORT_CONFIG, 16'hffff, 16'h1000);
    pulse(0, 16'h0000);
    idle(3);
    check(pulldown_enable_o, 4'h0);
    rd(`HPPS_IDX_PORT_CONFIG, 16'hffff, 16'h0000);
    wr(`HPPS_IDX_PORT_CONFIG, 32'h1000, 0);
    idle(3);
    check(pulldown_enable_o, 4'hf);
    $display("pull-down test done");
  endtask
  task automatic t_overcurrent();
    idle(10);
    check(pwr, 2'h3);
    ext_f = 2'h1;
    int_f = 2'h2;
    idle(10);
    check(pwr, 2'h2);
    wr(`HPPS_IDX_PORT_CONFIG, 32'h0400, 0);
    idle(10);
    check(pwr, 2'h1);
    ext_f = 2'h3;
    int_f = 2'h3;
    idle(10);
    check(pwr, 2'h0);
    ext_f = 2'h0;
    int_f = 2'h0;
    idle(10);
    check(pwr, 2'h3);
    $display("overcurrent test done");
  endtask
  task automatic t_suspend();
    wr(`HPPS_IDX_PORT_CONFIG, 32'h0800, 0);
    wr(`HPPS_IDX_EVENT_STATUS, 32'h0008, 1);
    wr(`HPPS_IDX_RUN_CONTROL, 32'h00c0, 1);
    idle(4);
    check(host_suspend_o, 1'b1);
    check(full_suspend_o, 1'b0);
    device_controller_suspended_i = 1;
    idle(1);
    check(full_suspend_o, 1'b0); // clock kept running, so no full suspend
    device_controller_suspended_i = 0;
    idle(300);
    check(clock_enable_o, 1'b1);
    port_resume_i = 1;
    idle(10);
    port_resume_i = 0;
    rd(`HPPS_IDX_EVENT_STATUS, 16'h0008, 16'h0008);
    rd(`HPPS_IDX_RUN_CONTROL, 16'h00c0, 16'h0040);
    rd(`HPPS_IDX_CPU_FLAGS, 16'h0040, 16'h0000); // clock never stopped
    wr(`HPPS_IDX_EVENT_STATUS, 32'h0008, 1);
    rd(`HPPS_IDX_EVENT_STATUS, 16'h0008, 16'h0000);
    check(host_suspend_o, 1'b1);
    wr(`HPPS_IDX_RUN_CONTROL, 32'h0080, 1);
    idle(4);
    check(host_suspend_o, 1'b0);
    $display("suspend test done");
  endtask
  initial begin
    repeat (3) @(posedge sys_clk_i);
    #1 rst_n_i = 1;
    t_pulldown();
    t_overcurrent();
    t_suspend();
    tally_and_finish();
  end
endmodule // hpps_top_tb
bind hpps_top hpps_checker u_chk (.sys_clk_i, .rst_n_i, .soft_reset_i, .data_wr_strobe_i,
  .port1_overcurrent_n_i, .port2_overcurrent_n_i, .analog_overcurrent_i,
  .port1_power_switch_n_o, .port1_power_switch_n_oe_o, .port2_power_switch_n_o,
  .pulldown_enable_o, .device_controller_suspended_i, .host_suspend_o, .full_suspend_o);
